// >>> pvs_pkg.sv
// constants and types shared by the printer video serializer
package pvs_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned PTR_W = 3;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned MARGIN_W = 12;
  localparam int unsigned BIT_W = 5;
  localparam int unsigned DIV_W = 3;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_VID_CFG = 32'h1D0000B0;
  localparam logic [ADDR_W-1:0] OFS_VID_CTL = 32'h1D0000B4;
  localparam logic [ADDR_W-1:0] OFS_DMA_ADDR = 32'h1D0000B8;
  localparam logic [ADDR_W-1:0] OFS_DMA_CNT = 32'h1D0000BC;
  localparam logic [ADDR_W-1:0] OFS_ENG_SCAN = 32'h1D0000C0;
  localparam logic [ADDR_W-1:0] OFS_LINE_WORD_COUNT = 32'h1D0000C4;
  localparam logic [ADDR_W-1:0] OFS_BAND_LINE_COUNT = 32'h1D0000C8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 32'h1D0000CC;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 32'h1D0000D0;

  // video configuration fields
  localparam int unsigned CFG_INVERT = 0;
  localparam int unsigned CFG_SHIFT_DIR = 1;
  localparam int unsigned CFG_PLL_BYPASS = 2;
  localparam int unsigned CFG_HMARGIN_LSB = 4;
  localparam int unsigned CFG_VMARGIN_LSB = 16;
  // video control fields
  localparam int unsigned CTL_COUNT_DIR = 0;
  localparam int unsigned CTL_DMA_START = 1;
  // engine scan fields
  localparam int unsigned SCAN_BLANK = 0;
  localparam int unsigned SCAN_AUTO_RELOAD = 1;
  // interrupt status / mask fields
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_LINE = 0;
  localparam int unsigned IRQ_BAND = 1;
  localparam int unsigned IRQ_FETCHED = 2;
  localparam int unsigned IRQ_PAGE = 3;
  localparam int unsigned STAT_DMA_BUSY = 8;
  localparam int unsigned STAT_VID_BUSY = 9;

  localparam logic [DATA_W-1:0] REG_RESET = 32'h00000000;
  localparam logic [ADDR_W-1:0] WORD_STEP = 32'h00000004;
  localparam logic [DIV_W-1:0] PLL_DIV_LAST = 3'h7;
  localparam logic [BIT_W-1:0] BIT_LAST = 5'h1F;

  typedef enum logic [0:0] {
    DMA_IDLE = 1'h0,
    DMA_FETCH = 1'h1
  } pvs_dma_t;

  typedef enum logic [2:0] {
    VID_IDLE = 3'h0,
    VID_VSKIP = 3'h1,
    VID_HSKIP = 3'h3,
    VID_SHIFT = 3'h2,
    VID_LINE_END = 3'h6
  } pvs_vid_t;
endpackage

// >>> pvs_top.sv
// printer video serializer: dma fetcher, word buffer, margin and shift logic, apb registers
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module pvs_top
  import pvs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic memReq,
  output logic [ADDR_W-1:0] memAddr,
  input wire logic memAck,
  input wire logic [DATA_W-1:0] memData,
  input wire logic video_clock_in,
  input wire logic page_sync_n,
  input wire logic line_sync_n,
  output logic pixel_shift_clock,
  output logic videoOut,
  output logic irq
);
  logic [DATA_W-1:0] cfg_reg, ctl_reg, shadowAddr_reg, shadowCnt_reg, scan_reg;
  logic [DATA_W-1:0] lineWords_reg, bandLines_reg;
  logic [IRQ_W-1:0] status_reg, mask_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic pready_reg, pslverr_reg, irq_reg;
  logic wrEn, accessStart, dmaStartReq;
  logic [DATA_W-1:0] readMux;
  logic readHit;

  logic [DATA_W-1:0] fifoMem [FIFO_DEPTH];
  logic [PTR_W-1:0] wrPtr_reg, rdPtr_reg;
  logic fifoFull, fifoEmpty, push, pop;

  pvs_dma_t dmaState_reg;
  logic [ADDR_W-1:0] dmaAddr_reg, memAddr_reg;
  logic [DATA_W-1:0] dmaCnt_reg;
  logic memReq_reg, fetchedEv;

  logic [2:0] vclkSync_reg, page_sync_n_reg, line_sync_n_reg;
  logic vclkLvl_reg, pageLvl_reg, lineLvl_reg;
  logic vclkRise, pageFall, lineFall, shiftTick;
  logic [DIV_W-1:0] div_reg;
  logic shiftClk_reg;

  pvs_vid_t vidState_reg;
  logic [MARGIN_W-1:0] vCnt_reg, hCnt_reg;
  logic vSkipping_reg;
  logic [CNT_W-1:0] wordsLeft_reg, linesLeft_reg;
  logic [DATA_W-1:0] shiftWord_reg;
  logic [BIT_W-1:0] bitCnt_reg;
  logic videoOut_reg, lineEv, bandEv;
  logic blankBand, wordAvail, curBit;

  // pixel taken from the current word in the chosen direction
  function automatic logic headBit(input logic [DATA_W-1:0] w, input logic lsbFirst);
    headBit = lsbFirst ? w[0] : w[DATA_W-1];
  endfunction

  function automatic logic [DATA_W-1:0] advance(input logic [DATA_W-1:0] w,
                                                input logic lsbFirst);
    advance = lsbFirst ? (w >> 1) : (w << 1);
  endfunction

  function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0] a,
                                                 input logic down);
    nextAddr = down ? (a - WORD_STEP) : (a + WORD_STEP);
  endfunction

  // ---------------- apb slave, one wait state ----------------
  assign accessStart = psel && penable && !pready_reg;
  assign wrEn = psel && penable && pwrite && pready_reg;
  assign dmaStartReq = wrEn && (paddr == OFS_VID_CTL) && pwdata[CTL_DMA_START];

  always_comb begin
    readHit = 1'b1;
    readMux = REG_RESET;
    case (paddr)
      OFS_VID_CFG: readMux = cfg_reg;
      OFS_VID_CTL: readMux = ctl_reg;
      OFS_DMA_ADDR: readMux = dmaAddr_reg;
      OFS_DMA_CNT: readMux = dmaCnt_reg;
      OFS_ENG_SCAN: readMux = scan_reg;
      OFS_LINE_WORD_COUNT: readMux = lineWords_reg;
      OFS_BAND_LINE_COUNT: readMux = bandLines_reg;
      OFS_IRQ_STATUS: begin
        readMux[IRQ_W-1:0] = status_reg;
        readMux[STAT_DMA_BUSY] = (dmaState_reg == DMA_FETCH);
        readMux[STAT_VID_BUSY] = (vidState_reg != VID_IDLE);
      end
      OFS_IRQ_MASK: readMux[IRQ_W-1:0] = mask_reg;
      default: readHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= REG_RESET;
    end else begin
      pready_reg <= accessStart;
      pslverr_reg <= accessStart && !readHit;
      if (accessStart && !pwrite) begin
        prdata_reg <= readMux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= REG_RESET;
      ctl_reg <= REG_RESET;
      shadowAddr_reg <= REG_RESET;
      shadowCnt_reg <= REG_RESET;
      scan_reg <= REG_RESET;
      lineWords_reg <= REG_RESET;
      bandLines_reg <= REG_RESET;
      mask_reg <= '0;
    end else if (wrEn) begin
      case (paddr)
        OFS_VID_CFG: cfg_reg <= pwdata;
        OFS_VID_CTL: ctl_reg <= {pwdata[DATA_W-1:CTL_DMA_START+1], 1'b0, pwdata[CTL_COUNT_DIR]};
        OFS_DMA_ADDR: shadowAddr_reg <= pwdata;
        OFS_DMA_CNT: shadowCnt_reg <= pwdata;
        OFS_ENG_SCAN: scan_reg <= pwdata;
        OFS_LINE_WORD_COUNT: lineWords_reg <= pwdata;
        OFS_BAND_LINE_COUNT: bandLines_reg <= pwdata;
        OFS_IRQ_MASK: mask_reg <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky events; a new event in the clearing cycle survives
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~((wrEn && paddr == OFS_IRQ_STATUS) ?
                     pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}}))
                    | {pageFall, fetchedEv, bandEv, lineEv};
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ---------------- word buffer ----------------
  assign fifoEmpty = (wrPtr_reg == rdPtr_reg);
  assign fifoFull = (wrPtr_reg[PTR_W-1] != rdPtr_reg[PTR_W-1]) &&
                    (wrPtr_reg[PTR_W-2:0] == rdPtr_reg[PTR_W-2:0]);
  assign push = memReq_reg && memAck;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      fifoMem[wrPtr_reg[PTR_W-2:0]] <= memData;
    end
  end

  // ---------------- dma fetcher ----------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dmaState_reg <= DMA_IDLE;
      dmaAddr_reg <= REG_RESET;
      dmaCnt_reg <= REG_RESET;
      memReq_reg <= 1'b0;
      memAddr_reg <= REG_RESET;
      wrPtr_reg <= '0;
      fetchedEv <= 1'b0;
    end else begin
      fetchedEv <= 1'b0;
      case (dmaState_reg)
        DMA_IDLE: begin
          if (dmaStartReq) begin
            dmaAddr_reg <= shadowAddr_reg;
            dmaCnt_reg <= shadowCnt_reg;
            dmaState_reg <= DMA_FETCH;
          end
        end
        DMA_FETCH: begin
          // one request outstanding, issued only with a free slot, so no overflow
          if (!memReq_reg && !fifoFull && dmaCnt_reg != REG_RESET) begin
            memReq_reg <= 1'b1;
            memAddr_reg <= dmaAddr_reg;
          end else if (push) begin
            memReq_reg <= 1'b0;
            wrPtr_reg <= wrPtr_reg + 1'b1;
            dmaAddr_reg <= nextAddr(dmaAddr_reg, ctl_reg[CTL_COUNT_DIR]);
            dmaCnt_reg <= dmaCnt_reg - 1'b1;
            if (dmaCnt_reg == 32'h00000001) begin
              fetchedEv <= 1'b1;
              if (scan_reg[SCAN_AUTO_RELOAD]) begin
                dmaAddr_reg <= shadowAddr_reg;
                dmaCnt_reg <= shadowCnt_reg;
              end else begin
                dmaState_reg <= DMA_IDLE;
              end
            end
          end else if (dmaCnt_reg == REG_RESET && !memReq_reg) begin
            dmaState_reg <= DMA_IDLE;
          end
        end
        default: dmaState_reg <= DMA_IDLE;
      endcase
    end
  end

  // ---------------- engine pins: three stages, level taken when last two agree ----
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vclkSync_reg <= '0;
      page_sync_n_reg <= 3'h7;
      line_sync_n_reg <= 3'h7;
      vclkLvl_reg <= 1'b0;
      pageLvl_reg <= 1'b1;
      lineLvl_reg <= 1'b1;
    end else begin
      vclkSync_reg <= {vclkSync_reg[1:0], video_clock_in};
      page_sync_n_reg <= {page_sync_n_reg[1:0], page_sync_n};
      line_sync_n_reg <= {line_sync_n_reg[1:0], line_sync_n};
      if (vclkSync_reg[1] == vclkSync_reg[2]) vclkLvl_reg <= vclkSync_reg[2];
      if (page_sync_n_reg[1] == page_sync_n_reg[2]) pageLvl_reg <= page_sync_n_reg[2];
      if (line_sync_n_reg[1] == line_sync_n_reg[2]) lineLvl_reg <= line_sync_n_reg[2];
    end
  end

  assign vclkRise = !vclkLvl_reg && (vclkSync_reg[1] == vclkSync_reg[2]) && vclkSync_reg[2];
  assign pageFall = pageLvl_reg && (page_sync_n_reg[1] == page_sync_n_reg[2]) && !page_sync_n_reg[2];
  assign lineFall = lineLvl_reg && (line_sync_n_reg[1] == line_sync_n_reg[2]) && !line_sync_n_reg[2];
  assign shiftTick = vclkRise &&
                     (cfg_reg[CFG_PLL_BYPASS] || div_reg == PLL_DIV_LAST);

  // divide-by-eight shift clock; restarts on line sync so pixels line up with it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= '0;
      shiftClk_reg <= 1'b0;
    end else begin
      if (lineFall) begin
        div_reg <= '0;
      end else if (vclkRise) begin
        div_reg <= div_reg + 1'b1;
      end
      shiftClk_reg <= cfg_reg[CFG_PLL_BYPASS] ? vclkLvl_reg : div_reg[DIV_W-1];
    end
  end

  // ---------------- video shifter ----------------
  assign blankBand = scan_reg[SCAN_BLANK];
  assign wordAvail = blankBand || !fifoEmpty;
  assign pop = (vidState_reg == VID_SHIFT) && shiftTick && bitCnt_reg == '0 &&
               !blankBand && !fifoEmpty;
  assign curBit = (bitCnt_reg == '0) ?
                  (blankBand ? 1'b0 : headBit(fifoMem[rdPtr_reg[PTR_W-2:0]],
                                              cfg_reg[CFG_SHIFT_DIR])) :
                  headBit(shiftWord_reg, cfg_reg[CFG_SHIFT_DIR]);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vidState_reg <= VID_IDLE;
      vCnt_reg <= '0;
      hCnt_reg <= '0;
      vSkipping_reg <= 1'b0;
      wordsLeft_reg <= '0;
      linesLeft_reg <= '0;
      shiftWord_reg <= REG_RESET;
      bitCnt_reg <= '0;
      rdPtr_reg <= '0;
      videoOut_reg <= 1'b0;
      lineEv <= 1'b0;
      bandEv <= 1'b0;
    end else begin
      lineEv <= 1'b0;
      bandEv <= 1'b0;
      if (pageFall) begin
        vCnt_reg <= cfg_reg[CFG_VMARGIN_LSB +: MARGIN_W];
        vSkipping_reg <= 1'b1;
        linesLeft_reg <= '0;
        videoOut_reg <= cfg_reg[CFG_INVERT];
        vidState_reg <= VID_VSKIP;
      end else if (lineFall && vidState_reg != VID_IDLE) begin
        if (vSkipping_reg) begin
          // field of n-1 leaves the skip after exactly n lines
          if (vCnt_reg == '0) vSkipping_reg <= 1'b0;
          else vCnt_reg <= vCnt_reg - 1'b1;
          vidState_reg <= VID_VSKIP;
        end else begin
          hCnt_reg <= cfg_reg[CFG_HMARGIN_LSB +: MARGIN_W];
          wordsLeft_reg <= lineWords_reg[CNT_W-1:0];
          if (linesLeft_reg == '0) linesLeft_reg <= bandLines_reg[CNT_W-1:0];
          bitCnt_reg <= '0;
          vidState_reg <= VID_HSKIP;
        end
        videoOut_reg <= cfg_reg[CFG_INVERT];
      end else if (shiftTick) begin
        case (vidState_reg)
          VID_HSKIP: begin
            if (hCnt_reg == '0) vidState_reg <= VID_SHIFT;
            else hCnt_reg <= hCnt_reg - 1'b1;
          end
          VID_SHIFT: begin
            // an empty buffer holds the line until a word lands; the pixel stays idle
            if (wordsLeft_reg == '0) begin
              videoOut_reg <= cfg_reg[CFG_INVERT];
              vidState_reg <= VID_LINE_END;
            end else if (bitCnt_reg != '0 || wordAvail) begin
              videoOut_reg <= curBit ^ cfg_reg[CFG_INVERT];
              bitCnt_reg <= bitCnt_reg + 1'b1;
              if (bitCnt_reg == '0) begin
                shiftWord_reg <= advance(blankBand ? REG_RESET :
                  fifoMem[rdPtr_reg[PTR_W-2:0]], cfg_reg[CFG_SHIFT_DIR]);
                if (pop) rdPtr_reg <= rdPtr_reg + 1'b1;
                if (wordsLeft_reg == 16'h0001) begin
                  lineEv <= 1'b1;
                  if (linesLeft_reg == 16'h0001) bandEv <= 1'b1;
                  linesLeft_reg <= linesLeft_reg - 1'b1;
                end
              end else begin
                shiftWord_reg <= advance(shiftWord_reg, cfg_reg[CFG_SHIFT_DIR]);
              end
              if (bitCnt_reg == BIT_LAST) wordsLeft_reg <= wordsLeft_reg - 1'b1;
            end else begin
              videoOut_reg <= cfg_reg[CFG_INVERT];
            end
          end
          VID_LINE_END, VID_VSKIP, VID_IDLE: ;
          default: vidState_reg <= VID_IDLE;
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign memReq = memReq_reg;
  assign memAddr = memAddr_reg;
  assign pixel_shift_clock = shiftClk_reg;
  assign videoOut = videoOut_reg;
  assign irq = irq_reg;
endmodule

// >>> pvs_chk.sv
// port-level assertions for the printer video serializer
`timescale 1ns/1ns
module pvs_chk
  import pvs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic memReq,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic memAck,
  input wire logic [DATA_W-1:0] memData,
  input wire logic video_clock_in,
  input wire logic page_sync_n,
  input wire logic line_sync_n,
  input wire logic pixel_shift_clock,
  input wire logic videoOut,
  input wire logic irq
);
  logic [IRQ_W-1:0] maskReg;
  logic bypassReg;
  logic mapped;
  // mirror of software writes so mode-dependent checks know the setup
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      maskReg <= '0;
      bypassReg <= 1'b0;
    end else if (psel && penable && pready && pwrite && !pslverr) begin
      if (paddr == OFS_IRQ_MASK) maskReg <= pwdata[IRQ_W-1:0];
      if (paddr == OFS_VID_CFG) bypassReg <= pwdata[CFG_PLL_BYPASS];
    end
  end
  assign mapped = paddr >= OFS_VID_CFG && paddr <= OFS_IRQ_MASK && paddr[1:0] == 2'h0;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  sequence sSetupAccess;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence sMemGrant;
    memReq && memAck;
  endsequence
  property pFollow;
    bypassReg && $rose(video_clock_in) |-> ##[1:6] $rose(pixel_shift_clock);
  endproperty
  chk_apb_ready_time: assert property (sSetupAccess |=> pready)
    else $error("pready missing on second access cycle");
  chk_apb_ready_cause: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside an access phase");
  chk_apb_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_apb_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match the address map");
  chk_apb_err_qual: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_mem_req_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
    else $error("memory request dropped or moved before ack");
  chk_mem_req_drop: assert property (sMemGrant |=> !memReq)
    else $error("memory request held after ack");
  chk_shift_follow: assert property (pFollow)
    else $error("shift clock does not follow the bypass clock");
  chk_video_hold: assert property ($changed(videoOut) |=> $stable(videoOut) [*3])
    else $error("video bit changed twice within one shift period");
  chk_irq_masked: assert property ($stable(maskReg) && maskReg == '0 |-> !irq)
    else $error("irq high with every source masked");
  chk_page_irq: assert property (maskReg[IRQ_PAGE] && $fell(page_sync_n) |-> ##[2:10] irq)
    else $error("no irq after page sync fall");
endmodule

bind pvs_top pvs_chk chk_u (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .memReq, .memAddr, .memAck, .memData, .video_clock_in,
  .page_sync_n, .line_sync_n, .pixel_shift_clock, .videoOut, .irq);

// >>> pvs_engine_model.sv
// printer engine model: supplied video clock and active-low page and line sync
`timescale 1ns/1ns
module pvs_engine_model (
  output logic video_clock_in,
  output logic page_sync_n,
  output logic line_sync_n
);
  // a whole number of system clocks keeps the sync-to-shift phase repeatable
  localparam int HALF_NS = 400;
  initial begin
    video_clock_in = 1'b0;
    page_sync_n = 1'b1;
    line_sync_n = 1'b1;
  end
  always begin
    #(HALF_NS) video_clock_in = ~video_clock_in;
  end
  task automatic sync_pulse(input logic page);
    @(negedge video_clock_in);
    if (page) page_sync_n <= 1'b0;
    else line_sync_n <= 1'b0;
    // held low for three input clocks, wider than one shift period in bypass mode
    repeat (3) @(negedge video_clock_in);
    page_sync_n <= 1'b1;
    line_sync_n <= 1'b1;
  endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the printer video serializer
`timescale 1ns/1ns
module tb_top;
  import pvs_pkg::*;
  localparam int MAX_CYCLES = 40000;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, memAck = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, memData = '0, prdata;
  logic [ADDR_W-1:0] memAddr;
  logic pready, pslverr, memReq, irq, videoOut, pixel_shift_clock;
  logic video_clock_in, page_sync_n, line_sync_n;
  int errors = 0, testsRun = 0, cycles = 0, nFetch = 0, lat = 0, k0 = -1;
  integer seed = 32'h260C38C2;
  logic [DATA_W-1:0] words [2];
  logic [ADDR_W-1:0] addrQ [$];
  logic capQ [$];

  always #50 clk_sys = ~clk_sys;

  pvs_engine_model eng_u (.video_clock_in, .page_sync_n, .line_sync_n);
  pvs_top dut_u (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .memReq, .memAddr, .memAck, .memData, .video_clock_in,
    .page_sync_n, .line_sync_n, .pixel_shift_clock, .videoOut, .irq);

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (errors == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
      input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] rd;
    logic err;
    apb(1'b0, a, '0, rd, err);
    check(rd & m, exp);
  endtask

  // samples mid-period of the shift clock, after the system edge has settled
  task automatic grab(input int n);
    capQ.delete();
    repeat (n) begin
      @(negedge pixel_shift_clock);
      @(negedge clk_sys);
      capQ.push_back(videoOut);
    end
  endtask

  function automatic logic [63:0] stream_of(logic lsb, logic inv);
    logic [63:0] s;
    for (int b = 0; b < 32; b++) begin
      s[63 - b] = (lsb ? words[0][b] : words[0][31 - b]) ^ inv;
      s[31 - b] = (lsb ? words[1][b] : words[1][31 - b]) ^ inv;
    end
    return s;
  endfunction

  function automatic int find(logic [63:0] pat);
    int at;
    at = -1;
    for (int s = capQ.size() - 64; s >= 0; s--) begin
      logic ok;
      ok = 1'b1;
      for (int b = 0; b < 64; b++) if (capQ[s + b] !== pat[63 - b]) ok = 1'b0;
      if (ok) at = s;
    end
    return at;
  endfunction

  // frame memory: random latency, the data bus toggles between grants
  always @(posedge clk_sys) begin
    if (memReq && !memAck && lat == 0) begin
      memAck <= 1'b1;
      memData <= words[nFetch % 2];
      addrQ.push_back(memAddr);
      nFetch <= nFetch + 1;
      lat <= $random(seed) & 3;
    end else begin
      memAck <= 1'b0;
      memData <= ~memData;
      if (memReq && !memAck) lat <= lat - 1;
    end
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    logic [DATA_W-1:0] rd, d;
    logic err, inv;
    int h, v, idx;
    logic [ADDR_W-1:0] base;
    time t0, t1, dly;
    // reset leaves the divided shift clock selected: five of its periods span forty inputs
    repeat (20) @(posedge clk_sys);
    repeat (41) @(posedge video_clock_in);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(1'b1, 32'h1D0000D4, 32'h0000A5A5, rd, err);
    check(err, 1'b1);
    apb(1'b0, 32'h1D0000D4, '0, rd, err);
    check(err, 1'b1);
    for (int r = 0; r < 2; r++) begin
      d = $random(seed);
      wr(r ? OFS_BAND_LINE_COUNT : OFS_LINE_WORD_COUNT, d);
      rdchk(r ? OFS_BAND_LINE_COUNT : OFS_LINE_WORD_COUNT, 32'h0000FFFF, d & 32'h0000FFFF);
    end
    // every pairing of address direction and shift direction
    for (int i = 0; i < 4; i++) begin
      h = $random(seed) & 7;
      v = i % 2;
      inv = i[0] ^ i[1];
      base = 32'h00040000 | ($random(seed) & 32'h0000FFFC);
      words[0] = $random(seed) | 32'h80000001;
      words[1] = $random(seed);
      nFetch = 0;
      addrQ.delete();
      wr(OFS_VID_CFG, {4'h0, 12'(v), 12'(h), 1'b0, 1'b1, i[1], inv});
      wr(OFS_VID_CTL, {31'h0, i[0]});
      wr(OFS_DMA_ADDR, base);
      wr(OFS_DMA_CNT, 32'h2);
      wr(OFS_LINE_WORD_COUNT, 32'h2);
      wr(OFS_BAND_LINE_COUNT, 32'h1);
      wr(OFS_ENG_SCAN, 32'h0);
      wr(OFS_IRQ_STATUS, 32'h0000000F);
      wr(OFS_IRQ_MASK, i ? 32'h8 : 32'h0);
      wr(OFS_VID_CTL, {30'h0, 1'b1, i[0]});
      while (nFetch < 2) @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      check(addrQ[0], base);
      check(addrQ[1], i[0] ? base - 32'h4 : base + 32'h4);
      rdchk(OFS_IRQ_STATUS, 32'hF, 32'h4);
      check(irq, 1'b0);
      eng_u.sync_pulse(1'b1);
      repeat (12) @(posedge clk_sys);
      check(irq, i != 0);
      rdchk(OFS_IRQ_STATUS, 32'hF, 32'hC);
      for (int ln = 0; ln <= v + 1; ln++) begin
        fork
          eng_u.sync_pulse(1'b0);
          grab(h + 90);
        join
        idx = find(stream_of(i[1], inv));
        if (ln <= v) begin
          check(idx, -1);
        end else begin
          if (k0 < 0 && idx >= 0) k0 = idx - h;
          check(idx >= 0, 1'b1);
          check(idx - h, k0);
        end
        rdchk(OFS_IRQ_STATUS, 32'hF, ln > v ? 32'hF : 32'hC);
      end
      wr(OFS_IRQ_STATUS, 32'h0000000F);
      repeat (3) @(posedge clk_sys);
      check(irq, 1'b0);
      rdchk(OFS_IRQ_STATUS, 32'hF, 32'h0);
    end
    // auto reload: each band-fetched event restarts from the shadows until the buffer fills
    nFetch = 0;
    addrQ.delete();
    wr(OFS_IRQ_STATUS, 32'h0000000F);
    wr(OFS_ENG_SCAN, 32'h00000002);
    wr(OFS_VID_CTL, 32'h00000002);
    while (nFetch < 4) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    check(nFetch, 4);
    check(addrQ[2], base);
    check(addrQ[3], base + 32'h4);
    rdchk(OFS_IRQ_STATUS, 32'h00000104, 32'h00000104);
    // blank band: idle pixels and line events, no word taken from the full buffer
    wr(OFS_ENG_SCAN, 32'h00000003);
    eng_u.sync_pulse(1'b1);
    for (int ln = 0; ln <= v + 1; ln++) begin
      fork
        eng_u.sync_pulse(1'b0);
        grab(h + 90);
      join
    end
    check(find(stream_of(1'b1, 1'b0)), -1);
    check(nFetch, 4);
    rdchk(OFS_IRQ_STATUS, 32'h0000000B, 32'h0000000B);
    // divided shift clock: eight input clocks per pixel, phase restarted by line sync
    wr(OFS_VID_CFG, 32'h00000000);
    for (int p = 0; p < 2; p++) begin
      repeat (($random(seed) & 7) + 1) @(negedge video_clock_in);
      fork
        eng_u.sync_pulse(1'b0);
        begin
          @(negedge line_sync_n);
          t0 = $time;
          repeat (6) @(posedge clk_sys);
          @(posedge pixel_shift_clock);
          t1 = $time;
          @(posedge pixel_shift_clock);
          check(32'($time - t1), 32'd6400);
        end
      join
      if (p == 0) dly = t1 - t0;
      check(32'(t1 - t0), 32'(dly));
    end
    end_of_test();
  end
endmodule
